/* hdl/twm_port.sv */
`timescale 1ns/100ps
`include "twm_regs.svh"

module twm_fifo #(
   parameter int WIDTH = `TWM_BYTE_BITS,
   parameter int DEPTH = `TWM_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic push;
   logic pop;

   assign o_in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
   assign o_out_valid = wr_reg != rd_reg;
   assign o_out_data = mem_reg[rd_reg[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule

module twm_port import twm_pkg::*; #(
   parameter int QTR = `TWM_QTR_CYCLES,
   parameter int FIFO_DEPTH = `TWM_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Bus lines, open drain
   input wire logic i_scl_in,
   output logic o_scl_out,
   output logic o_scl_oe,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Firmware control strobes
   input wire logic i_start_set,
   input wire logic i_start_clr,
   input wire logic i_stop_set,
   input wire logic i_start_sent_clr,
   input wire logic i_tx_done_clr,
   input wire logic i_rx_full_clr,
   input wire logic i_status_one_read,
   input wire logic i_tx_write,
   input wire logic [7:0] i_tx_data,
   input wire logic i_force_nack,
   input wire logic [6:0] i_own_slave_address,
   // Status
   output logic o_start_request,
   output logic o_stop_request,
   output logic o_start_sent_flag,
   output logic o_tx_done_flag,
   output logic o_rx_full_flag,
   output logic o_arb_lost_flag,
   output logic o_own_address_hit,
   output logic o_ack_seen,
   output logic o_xmit_mode,
   output logic o_bus_busy,
   // Receive buffer drain
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready
);
   twm_state_type state_reg, state_next;
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic [7:0] qcnt_reg;
   logic [1:0] phase_reg;
   logic [2:0] bit_reg;
   logic [7:0] shift_reg, tx_buf_reg, push_data_reg;
   logic scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;
   logic byte_tx_reg, lost_reg, addr_reg, after_reg, own_reg, loaded_reg;
   logic nack_reg;
   logic push_reg, fifo_ready;
   logic active, stretch, tick, last_q, byte_end, lose_now;
   logic ev_lost_end, ev_byte_rx, ack_end, ev_tx_ack, ev_nack_lost;
   logic ev_start_done, ev_stop_done;
   logic go_stop, go_rstart, go_addr, go_txd, go_rxd;
   logic [7:0] byte_in;

   function automatic logic flag_next(input logic cur, input logic set,
                                      input logic clr);
      // Hardware set wins over a clear in the same cycle
      return set || (cur && !clr);
   endfunction

   // ---------------------------------------------------------------
   // Line sampling and bus state
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
      end else begin
         {scl_s1, scl_s2, scl_d} <= {i_scl_in, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_d} <= {i_sda_in, sda_s1, sda_s2};
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bus_busy <= 1'b0;
      end else if (scl_s2 && scl_d && sda_d && !sda_s2) begin
         o_bus_busy <= 1'b1;
      end else if (scl_s2 && scl_d && !sda_d && sda_s2) begin
         o_bus_busy <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Bit timing
   // ---------------------------------------------------------------
   // A slave holding the clock low stretches the high quarters
   assign active = state_reg != ST_IDLE && state_reg != ST_HOLD;
   assign stretch = active && !scl_low_reg && !scl_s2;
   assign tick = active && !stretch && qcnt_reg == 8'(QTR - 1);
   assign last_q = tick && phase_reg == `TWM_LAST_PHASE;
   assign byte_end = state_reg == ST_BIT && last_q && bit_reg == `TWM_LAST_BIT;
   assign lose_now = state_reg == ST_BIT && last_q && byte_tx_reg &&
                     !lost_reg && shift_reg[7] && !sda_s2;
   assign byte_in = {shift_reg[6:0], sda_s2};
   assign ev_lost_end = byte_end && (lost_reg || lose_now);
   assign ev_byte_rx = byte_end && !byte_tx_reg;
   assign ack_end = state_reg == ST_ACK && last_q;
   assign ev_tx_ack = ack_end && byte_tx_reg;
   assign ev_nack_lost = ack_end && !byte_tx_reg && !sda_low_reg && !sda_s2;
   assign ev_start_done = state_reg == ST_START && last_q;
   assign ev_stop_done = state_reg == ST_STOP && tick &&
                         phase_reg == `TWM_STOP_PHASE;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         qcnt_reg <= 8'h00;
         phase_reg <= 2'h0;
         bit_reg <= 3'h0;
      end else begin
         if (state_next != state_reg || !active || tick) begin
            qcnt_reg <= 8'h00;
         end else if (!stretch) begin
            qcnt_reg <= qcnt_reg + 8'h01;
         end
         if (state_next != state_reg) begin
            phase_reg <= 2'h0;
         end else if (tick) begin
            phase_reg <= phase_reg + 2'h1;
         end
         if (state_reg != ST_BIT) begin
            bit_reg <= 3'h0;
         end else if (last_q) begin
            bit_reg <= bit_reg + 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   assign go_stop = state_reg == ST_HOLD && o_stop_request;
   assign go_rstart = state_reg == ST_HOLD && !go_stop && after_reg &&
                      o_start_request;
   assign go_addr = state_reg == ST_HOLD && !go_stop && !after_reg &&
                    loaded_reg;
   assign go_txd = state_reg == ST_HOLD && !go_stop && !go_rstart &&
                   after_reg && o_xmit_mode && !o_tx_done_flag;
   // Receive waits for flag clear and buffer room
   assign go_rxd = state_reg == ST_HOLD && !go_stop && !go_rstart &&
                   after_reg && !o_xmit_mode && !o_tx_done_flag &&
                   !o_rx_full_flag && fifo_ready;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (o_start_request && !o_stop_request && !o_bus_busy) begin
               state_next = ST_START;
            end
         end
         ST_START: begin
            if (last_q) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (go_stop) begin
               state_next = ST_STOP;
            end else if (go_rstart) begin
               state_next = ST_START;
            end else if (go_addr || go_txd || go_rxd) begin
               state_next = ST_BIT;
            end
         end
         ST_BIT: begin
            if (ev_lost_end) begin
               state_next = ST_IDLE;
            end else if (byte_end) begin
               state_next = ST_ACK;
            end
         end
         ST_ACK: begin
            if (ev_nack_lost) begin
               state_next = ST_IDLE;
            end else if (ack_end) begin
               state_next = ST_HOLD;
            end
         end
         ST_STOP: begin
            if (ev_stop_done) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_reg <= 8'h00;
         byte_tx_reg <= 1'b0;
         lost_reg <= 1'b0;
         addr_reg <= 1'b0;
         after_reg <= 1'b0;
         own_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else begin
         if (go_addr || go_txd) begin
            shift_reg <= tx_buf_reg;
         end else if (state_reg == ST_BIT && last_q) begin
            shift_reg <= byte_in;
         end
         if (go_addr || go_txd || go_rxd) begin
            byte_tx_reg <= !go_rxd;
            lost_reg <= 1'b0;
            addr_reg <= go_addr;
            // Taken per byte, so a change made while acking hits the next
            nack_reg <= go_rxd && i_force_nack;
         end else if (lose_now) begin
            lost_reg <= 1'b1;
         end
         if (ev_start_done) begin
            after_reg <= 1'b0;
         end else if (ack_end) begin
            after_reg <= 1'b1;
         end
         if (ev_start_done) begin
            own_reg <= 1'b1;
         end else if (state_next == ST_IDLE) begin
            own_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Line drivers
   // ---------------------------------------------------------------
   always_comb begin
      scl_low_next = scl_low_reg;
      sda_low_next = sda_low_reg;
      unique case (state_reg)
         ST_IDLE: begin
            scl_low_next = 1'b0;
            sda_low_next = 1'b0;
         end
         ST_START: begin
            scl_low_next = (phase_reg == 2'h0 && own_reg) ||
                           phase_reg == 2'h3;
            sda_low_next = phase_reg[1];
         end
         ST_HOLD: begin
            scl_low_next = 1'b1;
         end
         ST_BIT: begin
            scl_low_next = !phase_reg[1];
            if (phase_reg == 2'h0) begin
               // Lost master only clocks and listens
               sda_low_next = byte_tx_reg && !lost_reg && !shift_reg[7];
            end
         end
         ST_ACK: begin
            scl_low_next = !phase_reg[1];
            if (phase_reg == 2'h0) begin
               sda_low_next = !byte_tx_reg && !nack_reg;
            end
         end
         ST_STOP: begin
            scl_low_next = phase_reg == 2'h0;
            sda_low_next = phase_reg < 2'h2;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
      end else begin
         scl_low_reg <= scl_low_next;
         sda_low_reg <= sda_low_next;
      end
   end

   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;
   assign o_scl_oe = scl_low_reg;
   assign o_sda_oe = sda_low_reg;

   // ---------------------------------------------------------------
   // Control and status flags
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_start_request <= 1'b0;
         o_stop_request <= 1'b0;
         o_start_sent_flag <= 1'b0;
         o_tx_done_flag <= 1'b0;
         o_rx_full_flag <= 1'b0;
         o_arb_lost_flag <= 1'b0;
         o_own_address_hit <= 1'b0;
         o_ack_seen <= 1'b0;
         o_xmit_mode <= 1'b0;
         tx_buf_reg <= 8'h00;
         loaded_reg <= 1'b0;
      end else begin
         o_start_request <= flag_next(o_start_request, i_start_set,
                                      i_start_clr);
         // A stop request with the bus not owned is simply dropped
         o_stop_request <= flag_next(o_stop_request, i_stop_set,
            ev_stop_done || state_reg == ST_IDLE);
         o_start_sent_flag <= flag_next(o_start_sent_flag, ev_start_done,
                                        i_start_sent_clr);
         o_tx_done_flag <= flag_next(o_tx_done_flag, ev_tx_ack,
                                     i_tx_done_clr);
         o_rx_full_flag <= flag_next(o_rx_full_flag, ev_byte_rx,
                                     i_rx_full_clr);
         o_arb_lost_flag <= flag_next(o_arb_lost_flag,
            ev_lost_end || ev_nack_lost, i_status_one_read);
         o_own_address_hit <= flag_next(o_own_address_hit,
            ev_lost_end && addr_reg &&
            byte_in[7:1] == i_own_slave_address,
            ev_start_done || ev_stop_done);
         if (ev_tx_ack) begin
            o_ack_seen <= !sda_s2;
         end
         if (ev_start_done) begin
            o_xmit_mode <= 1'b1;
         end else if (lose_now || ev_stop_done || ev_nack_lost ||
                      (ev_tx_ack && addr_reg && shift_reg[0])) begin
            o_xmit_mode <= 1'b0;
         end
         if (i_tx_write) begin
            tx_buf_reg <= i_tx_data;
         end
         // A data byte left over must not go out as the next address
         loaded_reg <= flag_next(loaded_reg, i_tx_write,
                                 go_addr || ev_start_done);
      end
   end

   // ---------------------------------------------------------------
   // Receive buffer
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         push_reg <= 1'b0;
         push_data_reg <= 8'h00;
      end else begin
         push_reg <= ev_byte_rx || ev_lost_end;
         if (byte_end) begin
            push_data_reg <= byte_in;
         end
      end
   end

   // Room is checked before each read byte; a byte kept after arbitration loss is pushed unchecked
   twm_fifo #(.WIDTH(`TWM_BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_in_valid(push_reg),
      .i_in_data(push_data_reg),
      .o_in_ready(fifo_ready),
      .o_out_valid(o_rx_valid),
      .o_out_data(o_rx_data),
      .i_out_ready(i_rx_ready)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence s_start_out;
      ##[1:300] o_start_sent_flag;
   endsequence

   AST_FREE_BUS: assert property (
      state_reg == ST_IDLE && state_next == ST_START |-> !o_bus_busy)
      else $error("START left while bus busy");
   AST_ADDR_NOW: assert property (
      go_addr |=> state_reg == ST_BIT ##1 o_sda_oe == !tx_buf_reg[7])
      else $error("address byte did not start");
   AST_TX_DONE: assert property (ev_tx_ack |=> o_tx_done_flag)
      else $error("transmit-done not set");
   AST_RSTART: assert property (
      go_rstart |=> state_reg == ST_START ##0 s_start_out)
      else $error("repeated START missing");
   AST_STOP_CLR: assert property (
      ev_stop_done |=> !o_stop_request && !o_xmit_mode &&
      state_reg == ST_IDLE)
      else $error("STOP did not clear controls");
   AST_ARB_SWITCH: assert property (
      lose_now |=> !o_xmit_mode && !o_sda_oe)
      else $error("no switch on arbitration loss");
   AST_ARB_END: assert property (
      ev_lost_end |=> o_arb_lost_flag && push_reg &&
      state_reg == ST_IDLE)
      else $error("arbitration loss not flagged");
   AST_RX_ACK: assert property (
      ev_byte_rx && !nack_reg |=> o_rx_full_flag ##1 o_sda_oe)
      else $error("acknowledge not driven");
   AST_RX_NACK: assert property (
      ev_byte_rx && nack_reg |=> ##1 !o_sda_oe)
      else $error("negative acknowledge not driven");
   AST_RX_NEXT: assert property (go_rxd |=> state_reg == ST_BIT)
      else $error("next read byte did not start");
   AST_HOLD_LOW: assert property (state_reg == ST_HOLD |=> o_scl_oe)
      else $error("clock released while holding");
   AST_ARB_READ: assert property (
      i_status_one_read && !ev_lost_end && !ev_nack_lost |=>
      !o_arb_lost_flag)
      else $error("status read did not clear flag");
endmodule

/* hdl/twm_regs.svh */
// Function
// - Writing the address byte after a START starts shifting it at once.
// - Transmit-done flag sets after the address byte and its acknowledge bit.
// - Clearing transmit-done in transmit mode copies the buffer to the shifter.
// - Start request while owning the bus after a byte sends repeated START.
// - Stop request after the last byte sends STOP; clearing done sends nothing.
// - After a transmit STOP the port clears stop request and direction flag.
// - A driven 1 read back as 0 loses arbitration; port stops transmitting.
// - After loss clocks finish the byte, then arbitration flag and byte stored.
// - Loss in address byte matching own slave address sets the hit flag.
// - Read address acknowledge sets done, records acknowledge, clears direction.
// - Firmware clears done after read address; port transmits nothing further.
// - Reader acknowledges unless forced nack; receive flag sets when acking.
// - Clearing the receive flag starts shifting in the next byte once the buffer has room.
// - After a receive STOP the port clears stop request, direction stays 0.
// - During reads loss only while nacking; then no more clocks, flag set.
// - While transmit-done stays set the port holds the clock line low unless a START or STOP is requested.
// - A start request with the bus not owned sends START only once the bus is seen free.
// - Reading the first status register clears the arbitration-lost flag.
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH
`define TWM_CLK_PERIOD_NS 5
`define TWM_SCL_PERIOD_NS 160
`define TWM_QTR_CYCLES ((`TWM_SCL_PERIOD_NS / 4) / `TWM_CLK_PERIOD_NS)
`define TWM_FIFO_DEPTH 16
`define TWM_BYTE_BITS 8
`define TWM_LAST_BIT 3'h7
`define TWM_LAST_PHASE 2'h3
`define TWM_STOP_PHASE 2'h2
`endif

/* hdl/twm_pkg.sv */
package twm_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_START = 6'h02,
      ST_HOLD  = 6'h04,
      ST_BIT   = 6'h08,
      ST_ACK   = 6'h10,
      ST_STOP  = 6'h20
   } twm_state_type;
endpackage

/* tb/twm_slave_model.sv */
`timescale 1ns/100ps
// Behavioural slave; released lines float high through the pull-ups
module twm_slave_model #(
   parameter logic [6:0] ADDR = 7'h50
) (
   // Bus side
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_low = 1'b0,
   output logic o_scl_low = 1'b0,
   // Bench side
   input wire logic [7:0] i_read_base,
   input wire logic i_stretch,
   output logic [7:0] o_byte = 8'h00,
   output logic o_got_byte = 1'b0
);
   int n = 0;
   logic [7:0] sh = 8'h00, k = 8'h00, cur;
   logic act = 1'b0, adr = 1'b0, rd = 1'b0, hit = 1'b0;
   always @(negedge i_sda) if (i_scl) begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      n = 0;
   end
   always @(posedge i_sda) if (i_scl) begin
      act = 1'b0;
      o_sda_low = 1'b0;
   end
   always @(posedge i_scl) if (act) begin
      if (n < 8) sh = {sh[6:0], i_sda};
      else if (rd && !adr && i_sda) act = 1'b0;
      if (n == 7 && adr) begin
         rd = sh[0];
         hit = sh[7:1] == ADDR;
      end
      if (n == 7 && !(rd && !adr)) begin
         o_byte = sh;
         o_got_byte = !o_got_byte;
      end
      n = n + 1;
   end
   always @(negedge i_scl) if (act) begin
      if (n == 9) begin
         n = 0;
         if (rd && !adr) k = k + 8'h01;
         if (adr && !hit) act = 1'b0;
         adr = 1'b0;
      end
      cur = i_read_base + k;
      if (n == 8) o_sda_low = adr ? hit : !rd;
      else o_sda_low = act && rd && !adr && !cur[7 - n];
      // A slow slave stretches the low half of each first bit
      if (act && n == 0 && i_stretch) begin
         o_scl_low = 1'b1;
         #400 o_scl_low = 1'b0;
      end
   end
endmodule

/* tb/twm_port_tb_top.sv */
`timescale 1ns/100ps
module twm_port_tb_top;
   import twm_pkg::*;
   logic i_clock = 1'b0, i_rst_n = 1'b0, sl_scl, sl_sda, cm_sda = 1'b0;
   logic o_scl_oe, o_sda_oe, o_scl_out, o_sda_out;
   wire i_scl_in = !(o_scl_oe || sl_scl);
   wire i_sda_in = !(o_sda_oe || sl_sda || cm_sda);
   logic i_start_set = 1'b0, i_start_clr = 1'b0, i_stop_set = 1'b0;
   logic i_start_sent_clr = 1'b0, i_tx_done_clr = 1'b0;
   logic i_rx_full_clr = 1'b0, i_status_one_read = 1'b0;
   logic i_tx_write = 1'b0, i_force_nack = 1'b0, i_rx_ready = 1'b0;
   logic [7:0] i_tx_data = 8'h00, o_rx_data, rbase = 8'h00, wbyte;
   logic [6:0] i_own_slave_address = 7'h00;
   logic o_start_request, o_stop_request, o_start_sent_flag;
   logic o_tx_done_flag, o_rx_full_flag, o_arb_lost_flag;
   logic o_own_address_hit, o_ack_seen, o_xmit_mode, o_bus_busy;
   logic o_rx_valid, got, drain = 1'b0, stretch = 1'b1;
   integer seed = 32'h13dcee7f;
   int n_fail = 0, samples_checked = 0, i;
   logic [7:0] exp_rx[$], exp_wire[$];

   twm_port uut (.i_clock, .i_rst_n, .i_scl_in, .o_scl_out, .o_scl_oe,
      .i_sda_in, .o_sda_out, .o_sda_oe, .i_start_set, .i_start_clr,
      .i_stop_set, .i_start_sent_clr, .i_tx_done_clr, .i_rx_full_clr,
      .i_status_one_read, .i_tx_write, .i_tx_data, .i_force_nack,
      .i_own_slave_address, .o_start_request, .o_stop_request,
      .o_start_sent_flag, .o_tx_done_flag, .o_rx_full_flag,
      .o_arb_lost_flag, .o_own_address_hit, .o_ack_seen, .o_xmit_mode,
      .o_bus_busy, .o_rx_valid, .o_rx_data, .i_rx_ready);
   twm_slave_model #(.ADDR(7'h50)) slave (.i_scl(i_scl_in),
      .i_sda(i_sda_in), .o_sda_low(sl_sda), .o_scl_low(sl_scl),
      .i_read_base(rbase), .i_stretch(stretch), .o_byte(wbyte),
      .o_got_byte(got));

   initial forever #2.5 i_clock = !i_clock;

   // -------------------------------------------------
   // Shared tasks
   // -------------------------------------------------
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clock);
      s = 1'b1;
      @(negedge i_clock);
      s = 1'b0;
   endtask
   task automatic wait_on(ref logic f, input logic v);
      int t;
      for (t = 0; t < 20000 && f !== v; t++) @(negedge i_clock);
      if (f !== v) begin
         n_fail++;
         $display("Error at %0t: wait timed out", $time);
         print_verdict();
      end
   endtask
   task automatic send(input logic [7:0] b);
      exp_wire.push_back(b);
      i_tx_data = b;
      pulse(i_tx_write);
   endtask
   task automatic open_with(input logic [7:0] b);
      pulse(i_start_set);
      wait_on(o_start_sent_flag, 1'b1);
      chk(o_xmit_mode === 1'b1, "transmit mode after start");
      send(b);
      pulse(i_start_sent_clr);
      pulse(i_start_clr);
      wait_on(o_tx_done_flag, 1'b1);
      chk(o_ack_seen === 1'b1, "address acknowledge");
   endtask

   // -------------------------------------------------
   // Result watchers
   // -------------------------------------------------
   always @(negedge i_clock) i_rx_ready <= drain & 1'($random(seed));
   always @(posedge i_clock) if (o_rx_valid && i_rx_ready) begin
      chk(exp_rx.size() > 0 && o_rx_data === exp_rx.pop_front(),
         "receive buffer byte");
   end
   always @(got) if (i_rst_n) begin
      chk(exp_wire.size() > 0 && wbyte === exp_wire.pop_front(),
         "byte on the wire");
   end

   initial begin
      rbase = 8'($random(seed));
      repeat (5) @(posedge i_clock);
      @(negedge i_clock);
      i_rst_n = 1'b1;
      // Write to a slow slave, then STOP
      open_with(8'hA0);
      repeat (100) @(negedge i_clock);
      chk(i_scl_in === 1'b0, "clock held while done");
      send(8'($random(seed)));
      pulse(i_tx_done_clr);
      wait_on(o_tx_done_flag, 1'b0);
      wait_on(o_tx_done_flag, 1'b1);
      pulse(i_stop_set);
      pulse(i_tx_done_clr);
      wait_on(o_stop_request, 1'b0);
      chk(o_xmit_mode === 1'b0, "direction after stop");
      // Write address, repeated START, read 18 bytes
      stretch = 1'b0;
      open_with(8'hA0);
      pulse(i_start_set);
      wait_on(o_start_sent_flag, 1'b1);
      pulse(i_start_sent_clr);
      send(8'hA1);
      pulse(i_tx_done_clr);
      pulse(i_start_clr);
      wait_on(o_tx_done_flag, 1'b1);
      chk(o_xmit_mode === 1'b0 && o_ack_seen === 1'b1,
         "read address phase");
      pulse(i_tx_done_clr);
      for (i = 0; i < 18; i++) begin
         wait_on(o_rx_full_flag, 1'b1);
         // Acknowledge goes out one cycle after the flag
         @(negedge i_clock);
         exp_rx.push_back(rbase + 8'(i));
         chk(o_sda_oe === !i_force_nack, "acknowledge level");
         if (i == 16) i_force_nack = 1'b1;
         if (i == 17) pulse(i_stop_set);
         pulse(i_rx_full_clr);
         if (i == 15) begin
            // Buffer full: next byte must wait with the clock held
            repeat (600) @(negedge i_clock);
            chk(o_rx_full_flag === 1'b0 && i_scl_in === 1'b0,
               "full buffer stalls reading");
            drain = 1'b1;
         end
      end
      wait_on(o_stop_request, 1'b0);
      i_force_nack = 1'b0;
      chk(o_xmit_mode === 1'b0, "receive mode after stop");
      // Competing master holds SDA low through our address byte
      pulse(i_start_set);
      wait_on(o_start_sent_flag, 1'b1);
      cm_sda = 1'b1;
      exp_wire.push_back(8'h00);
      exp_rx.push_back(8'h00);
      i_tx_data = 8'hA0;
      pulse(i_tx_write);
      pulse(i_start_sent_clr);
      pulse(i_start_clr);
      wait_on(o_arb_lost_flag, 1'b1);
      chk(o_own_address_hit === 1'b1 && o_xmit_mode === 1'b0,
         "own address seen after loss");
      cm_sda = 1'b0;
      pulse(i_status_one_read);
      wait_on(o_arb_lost_flag, 1'b0);
      // Absent slave refuses the address, abort with STOP
      pulse(i_start_set);
      wait_on(o_start_sent_flag, 1'b1);
      send(8'h42);
      pulse(i_start_sent_clr);
      pulse(i_start_clr);
      wait_on(o_tx_done_flag, 1'b1);
      chk(o_ack_seen === 1'b0, "negative acknowledge seen");
      pulse(i_stop_set);
      pulse(i_tx_done_clr);
      wait_on(o_stop_request, 1'b0);
      // One-byte read whose nack another master overrides
      i_force_nack = 1'b1;
      open_with(8'hA1);
      exp_rx.push_back(rbase + 8'h11);
      pulse(i_tx_done_clr);
      wait_on(o_rx_full_flag, 1'b1);
      cm_sda = 1'b1;
      wait_on(o_arb_lost_flag, 1'b1);
      repeat (100) @(negedge i_clock);
      chk(i_scl_in && o_bus_busy, "clocks stop after loss");
      cm_sda = 1'b0;
      i_force_nack = 1'b0;
      pulse(i_rx_full_clr);
      pulse(i_status_one_read);
      wait_on(o_arb_lost_flag, 1'b0);
      repeat (300) @(negedge i_clock);
      chk(exp_rx.size() == 0 && exp_wire.size() == 0, "all results seen");
      print_verdict();
   end
endmodule
